// ---- src/agss_pkg.sv ----
// shared widths, timing counts and states for the graphics port strobe block
package agss_pkg;
   localparam int AD_W       = 32;
   localparam int CBE_W      = 4;
   localparam int HALF_AD_W  = 16;
   localparam int HALF_CBE_W = 2;
   localparam int HALF_W     = HALF_AD_W + HALF_CBE_W;
   localparam int WORD_W     = AD_W + CBE_W;
   localparam int SBA_W      = 8;
   localparam int CNT_W      = 4;
   localparam int FIFO_DEPTH = 2;

   localparam logic STB_PARK = 1'b0;

   localparam int REF_PERIOD_NS = 8;
   localparam int SETUP_2X_NS   = 32;
   localparam int HOLD_2X_NS    = 32;
   localparam int SETUP_4X_NS   = 16;
   localparam int HOLD_4X_NS    = 16;

   // least times, so round up to whole cycles
   localparam logic [CNT_W-1:0] SETUP_2X_CYC =
      CNT_W'((SETUP_2X_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS);
   localparam logic [CNT_W-1:0] HOLD_2X_CYC =
      CNT_W'((HOLD_2X_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS);
   localparam logic [CNT_W-1:0] SETUP_4X_CYC =
      CNT_W'((SETUP_4X_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS);
   localparam logic [CNT_W-1:0] HOLD_4X_CYC =
      CNT_W'((HOLD_4X_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS);

   typedef enum logic [2:0] {
      TX_IDLE  = 3'b001,
      TX_SETUP = 3'b010,
      TX_HOLD  = 3'b100
   } agss_tx_state_t;
endpackage

// ---- src/agss_link_if.sv ----
// link wires between the hub end and the graphics master end
`timescale 1ns/1ns
`default_nettype none
interface agss_link_if;
   logic [agss_pkg::AD_W-1:0]  hub_ad_o;
   logic [agss_pkg::CBE_W-1:0] hub_cmd_byte_enables_o;
   logic                       hub_ad_oe;
   logic [1:0]                 hub_stb_o;
   logic [1:0]                 hub_stb_n_o;
   logic                       hub_stb_oe;
   logic                       hub_stb_n_oe;
   logic [agss_pkg::AD_W-1:0]  mst_ad_o;
   logic [agss_pkg::CBE_W-1:0] mst_cmd_byte_enables_o;
   logic                       mst_ad_oe;
   logic [1:0]                 mst_stb_o;
   logic [1:0]                 mst_stb_n_o;
   logic                       mst_stb_oe;
   logic                       mst_stb_n_oe;
   logic [agss_pkg::SBA_W-1:0] mst_sba_o;
   logic                       mst_sb_stb_o;
   logic                       mst_sb_stb_n_o;
   logic                       mst_sba_oe;
   logic                       mst_sb_stb_n_oe;

   // resolved wire levels; an undriven wire reads low
   logic [agss_pkg::AD_W-1:0]  ad;
   logic [agss_pkg::CBE_W-1:0] port_cmd_byte_enables;
   logic [1:0]                 ad_stb;
   logic [1:0]                 ad_stb_n;
   logic [agss_pkg::SBA_W-1:0] sba;
   logic                       sb_stb;
   logic                       sb_stb_n;

   assign ad = hub_ad_oe ? hub_ad_o : (mst_ad_oe ? mst_ad_o : '0);
   assign port_cmd_byte_enables = hub_ad_oe ? hub_cmd_byte_enables_o :
                                  (mst_ad_oe ? mst_cmd_byte_enables_o : '0);
   assign ad_stb   = hub_stb_oe ? hub_stb_o : (mst_stb_oe ? mst_stb_o : 2'h0);
   assign ad_stb_n = hub_stb_n_oe ? hub_stb_n_o : (mst_stb_n_oe ? mst_stb_n_o : 2'h0);
   assign sba      = mst_sba_oe ? mst_sba_o : '0;
   assign sb_stb   = mst_sba_oe ? mst_sb_stb_o : 1'b0;
   assign sb_stb_n = mst_sb_stb_n_oe ? mst_sb_stb_n_o : 1'b0;

   modport hub_mp (
      output hub_ad_o, hub_cmd_byte_enables_o, hub_ad_oe, hub_stb_o, hub_stb_n_o,
             hub_stb_oe, hub_stb_n_oe,
      input  ad, port_cmd_byte_enables, ad_stb, ad_stb_n, sba, sb_stb, sb_stb_n
   );
   modport mst_mp (
      output mst_ad_o, mst_cmd_byte_enables_o, mst_ad_oe, mst_stb_o, mst_stb_n_o,
             mst_stb_oe, mst_stb_n_oe, mst_sba_o, mst_sb_stb_o, mst_sb_stb_n_o,
             mst_sba_oe, mst_sb_stb_n_oe,
      input  ad, port_cmd_byte_enables, ad_stb, ad_stb_n
   );
endinterface
`default_nettype wire

// ---- src/agss_hub.sv ----
// hub end of the graphics port strobes, with the strobe launcher and capture
// What this block does
// - 2X: strobe 0 times low data half
// - 2X: strobe 1 times upper data half
// - 2X: strobe 0 complement is ignored
// - 2X: strobe 1 complement is unused
// - 4X: pair 0 times low half differentially
// - 4X: pair 1 times upper half differentially
// - data source drives the data strobes
// - 2X: side-band strobe times side-band bus
// - 4X: side-band pair times side-band bus
// - master alone drives side-band strobes
// - 2X: side-band complement is ignored
// - master queues requests over side-band bus
`timescale 1ns/1ns
`default_nettype none

// launches one word per strobe edge; data is set up before and held after the edge
module agss_strobe_tx #(
   parameter int W = 8
) (
   input  wire logic         ref_clk_i,  // port clock
   input  wire logic         rst_i,      // async reset
   input  wire logic         own_i,      // this end sources the lines
   input  wire logic         quad_i,     // 1: 4X, 0: 2X
   input  wire logic         valid_i,    // word waiting
   output logic              ready_o,    // word taken
   input  wire logic [W-1:0] word_i,     // word to send
   output logic [W-1:0]      data_o,     // line data
   output logic              stb_o,      // true strobe
   output logic              stb_n_o,    // complement strobe
   output logic              oe_o,       // data and true strobe enable
   output logic              stb_n_oe_o  // complement enable
);
   agss_pkg::agss_tx_state_t st_q, st_d;
   logic [agss_pkg::CNT_W-1:0] cnt_q, cnt_d;
   logic [W-1:0] data_q, data_d;
   logic         stb_q, stb_d;
   logic [agss_pkg::CNT_W-1:0] setup_cyc, hold_cyc;

   assign setup_cyc  = quad_i ? agss_pkg::SETUP_4X_CYC : agss_pkg::SETUP_2X_CYC;
   assign hold_cyc   = quad_i ? agss_pkg::HOLD_4X_CYC : agss_pkg::HOLD_2X_CYC;
   assign ready_o    = own_i & (st_q == agss_pkg::TX_IDLE);
   assign data_o     = data_q;
   assign stb_o      = stb_q;
   assign stb_n_o    = ~stb_q;
   assign oe_o       = own_i;
   assign stb_n_oe_o = own_i & quad_i;

   always_comb begin
      st_d   = st_q;
      cnt_d  = cnt_q;
      data_d = data_q;
      stb_d  = stb_q;
      if (!own_i) begin
         st_d  = agss_pkg::TX_IDLE;
         stb_d = agss_pkg::STB_PARK;
      end else begin
         case (st_q)
            agss_pkg::TX_IDLE: begin
               if (valid_i) begin
                  data_d = word_i;
                  cnt_d  = setup_cyc - agss_pkg::CNT_W'(1);
                  st_d   = agss_pkg::TX_SETUP;
               end
            end
            agss_pkg::TX_SETUP: begin
               if (cnt_q == '0) begin
                  stb_d = ~stb_q;
                  cnt_d = hold_cyc - agss_pkg::CNT_W'(1);
                  st_d  = agss_pkg::TX_HOLD;
               end else begin
                  cnt_d = cnt_q - agss_pkg::CNT_W'(1);
               end
            end
            agss_pkg::TX_HOLD: begin
               if (cnt_q == '0) begin
                  st_d = agss_pkg::TX_IDLE;
               end else begin
                  cnt_d = cnt_q - agss_pkg::CNT_W'(1);
               end
            end
            default: begin
               st_d = agss_pkg::TX_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_q   <= agss_pkg::TX_IDLE;
         cnt_q  <= '0;
         data_q <= '0;
         stb_q  <= agss_pkg::STB_PARK;
      end else begin
         st_q   <= st_d;
         cnt_q  <= cnt_d;
         data_q <= data_d;
         stb_q  <= stb_d;
      end
   end
endmodule

// samples a strobe and its lines through two flops, pulses cap_o on each strobe edge
module agss_strobe_rx #(
   parameter int W = 8
) (
   input  wire logic         ref_clk_i, // port clock
   input  wire logic         rst_i,     // async reset
   input  wire logic         quad_i,    // 1: 4X, 0: 2X
   input  wire logic         ignore_i,  // this end drives the lines
   input  wire logic         stb_i,     // true strobe pin
   input  wire logic         stb_n_i,   // complement strobe pin
   input  wire logic [W-1:0] data_i,    // line pins
   output logic              cap_o,     // one-cycle capture pulse
   output logic [W-1:0]      data_o     // captured word
);
   logic [W+1:0] s1_q, s2_q;
   logic         last_q, last_d;
   logic         cap_q, cap_d;
   logic [W-1:0] data_q, data_d;
   logic         pair_ok, s_stb, s_stb_n, ign;
   logic [2:0]   ig_q, ig_d;

   assign s_stb   = s2_q[W];
   assign s_stb_n = s2_q[W+1];
   // in 4X a strobe level counts only once the pair has crossed, which hides skew
   assign pair_ok = quad_i ? (s_stb != s_stb_n) : 1'b1;
   assign cap_o   = cap_q;
   assign data_o  = data_q;

   always_comb begin
      ig_d   = {ig_q[1:0], ignore_i};
      ign    = ignore_i | (|ig_q);  // sync flops lag the pins, so a handover is no edge
      last_d = pair_ok ? s_stb : last_q;
      cap_d  = pair_ok && (s_stb != last_q) && !ign;
      data_d = cap_d ? s2_q[W-1:0] : data_q;
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         s1_q   <= '0;
         s2_q   <= '0;
         last_q <= agss_pkg::STB_PARK;
         cap_q  <= 1'b0;
         ig_q   <= '0;
         data_q <= '0;
      end else begin
         s1_q   <= {stb_n_i, stb_i, data_i};
         s2_q   <= s1_q;
         last_q <= last_d;
         cap_q  <= cap_d;
         ig_q   <= ig_d;
         data_q <= data_d;
      end
   end
endmodule

module agss_hub (
   input  wire logic                          ref_clk_i,     // port clock
   input  wire logic                          rst_i,         // async reset
   input  wire logic                          quad_i,        // 1: 4X, 0: 2X
   input  wire logic                          own_ad_i,      // hub sources the data lines
   input  wire logic                          tx_valid_i,    // word to send
   output logic                               tx_ready_o,    // buffer has room
   input  wire logic [agss_pkg::WORD_W-1:0]   tx_word_i,     // {cmd/be, data}
   output logic                               rx_valid_o,    // received word held
   input  wire logic                          rx_ready_i,    // taker ready
   output logic [agss_pkg::WORD_W-1:0]        rx_word_o,     // {cmd/be, data}
   output logic                               rx_overrun_o,  // word lost, buffer full
   output logic                               sba_valid_o,   // side-band byte held
   input  wire logic                          sba_ready_i,   // taker ready
   output logic [agss_pkg::SBA_W-1:0]         sba_o,         // side-band byte
   output logic                               sba_overrun_o, // byte lost, buffer full
   agss_link_if.hub_mp                        link           // port wires
);
   logic                          tq_valid, tq_ready;
   logic [agss_pkg::WORD_W-1:0]   tq_word, tx_data;
   logic                          tx_stb, tx_stb_n, tx_oe, tx_n_oe;
   logic                          cap_lo, cap_hi, cap_sb;
   logic [agss_pkg::HALF_W-1:0]   lo_data, hi_data;
   logic [agss_pkg::SBA_W-1:0]    sb_data;
   logic                          lo_q, lo_d, hi_q, hi_d;
   logic                          push, rq_ready, sq_ready;
   logic                          ovr_q, ovr_d, sovr_q, sovr_d;

   agss_fifo2 #(.W(agss_pkg::WORD_W)) u_txq (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i),
      .in_valid_i(tx_valid_i), .in_ready_o(tx_ready_o), .in_data_i(tx_word_i),
      .out_valid_o(tq_valid), .out_ready_i(tq_ready), .out_data_o(tq_word)
   );

   agss_strobe_tx #(.W(agss_pkg::WORD_W)) u_tx (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i), .own_i(own_ad_i), .quad_i(quad_i),
      .valid_i(tq_valid), .ready_o(tq_ready), .word_i(tq_word), .data_o(tx_data),
      .stb_o(tx_stb), .stb_n_o(tx_stb_n), .oe_o(tx_oe), .stb_n_oe_o(tx_n_oe)
   );

   // both halves launch on the same instant, each with its own strobe
   assign link.hub_ad_o               = tx_data[agss_pkg::AD_W-1:0];
   assign link.hub_cmd_byte_enables_o = tx_data[agss_pkg::WORD_W-1:agss_pkg::AD_W];
   assign link.hub_ad_oe              = tx_oe;
   assign link.hub_stb_o              = {tx_stb, tx_stb};
   assign link.hub_stb_n_o            = {tx_stb_n, tx_stb_n};
   assign link.hub_stb_oe             = tx_oe;
   assign link.hub_stb_n_oe           = tx_n_oe;

   agss_strobe_rx #(.W(agss_pkg::HALF_W)) u_rx_lo (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i), .quad_i(quad_i), .ignore_i(own_ad_i),
      .stb_i(link.ad_stb[0]), .stb_n_i(link.ad_stb_n[0]),
      .data_i({link.port_cmd_byte_enables[1:0], link.ad[15:0]}),
      .cap_o(cap_lo), .data_o(lo_data)
   );

   agss_strobe_rx #(.W(agss_pkg::HALF_W)) u_rx_hi (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i), .quad_i(quad_i), .ignore_i(own_ad_i),
      .stb_i(link.ad_stb[1]), .stb_n_i(link.ad_stb_n[1]),
      .data_i({link.port_cmd_byte_enables[3:2], link.ad[31:16]}),
      .cap_o(cap_hi), .data_o(hi_data)
   );

   // the hub only listens on the side-band strobes
   agss_strobe_rx #(.W(agss_pkg::SBA_W)) u_rx_sb (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i), .quad_i(quad_i), .ignore_i(1'b0),
      .stb_i(link.sb_stb), .stb_n_i(link.sb_stb_n), .data_i(link.sba),
      .cap_o(cap_sb), .data_o(sb_data)
   );

   // a word is whole once both halves have been caught; a fresh half beats the clear
   assign push = lo_q & hi_q;

   always_comb begin
      lo_d   = cap_lo | (lo_q & ~push);
      hi_d   = cap_hi | (hi_q & ~push);
      ovr_d  = push & ~rq_ready;
      sovr_d = cap_sb & ~sq_ready;
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         lo_q   <= 1'b0;
         hi_q   <= 1'b0;
         ovr_q  <= 1'b0;
         sovr_q <= 1'b0;
      end else begin
         lo_q   <= lo_d;
         hi_q   <= hi_d;
         ovr_q  <= ovr_d;
         sovr_q <= sovr_d;
      end
   end

   assign rx_overrun_o  = ovr_q;
   assign sba_overrun_o = sovr_q;

   // the far end has no back-pressure here, so a stalled taker can only be reported
   agss_fifo2 #(.W(agss_pkg::WORD_W)) u_rxq (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i),
      .in_valid_i(push), .in_ready_o(rq_ready),
      .in_data_i({hi_data[agss_pkg::HALF_W-1:agss_pkg::HALF_AD_W],
                  lo_data[agss_pkg::HALF_W-1:agss_pkg::HALF_AD_W],
                  hi_data[agss_pkg::HALF_AD_W-1:0], lo_data[agss_pkg::HALF_AD_W-1:0]}),
      .out_valid_o(rx_valid_o), .out_ready_i(rx_ready_i), .out_data_o(rx_word_o)
   );

   agss_fifo2 #(.W(agss_pkg::SBA_W)) u_sbq (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i),
      .in_valid_i(cap_sb), .in_ready_o(sq_ready), .in_data_i(sb_data),
      .out_valid_o(sba_valid_o), .out_ready_i(sba_ready_i), .out_data_o(sba_o)
   );
endmodule
`default_nettype wire

// ---- src/agss_master.sv ----
// graphics master end: sends data and side-band bytes, receives hub data; shared buffer
`timescale 1ns/1ns
`default_nettype none
// two-entry buffer used by both ends; a full buffer refuses the word
module agss_fifo2 #(
   parameter int W     = 8,
   parameter int DEPTH = agss_pkg::FIFO_DEPTH
) (
   input  wire logic         ref_clk_i,   // port clock
   input  wire logic         rst_i,       // async reset
   input  wire logic         in_valid_i,  // word offered
   output logic              in_ready_o,  // room for it
   input  wire logic [W-1:0] in_data_i,   // word in
   output logic              out_valid_o, // word held
   input  wire logic         out_ready_i, // taker ready
   output logic [W-1:0]      out_data_o   // word out
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [W-1:0]  mem_q [DEPTH];
   logic [W-1:0]  mem_d [DEPTH];
   logic [PW-1:0] wp_q, wp_d, rp_q, rp_d;
   logic [PW:0]   cnt_q, cnt_d;
   logic          push, pop;

   assign in_ready_o  = (cnt_q != (PW+1)'(DEPTH));
   assign out_valid_o = (cnt_q != '0);
   assign out_data_o  = mem_q[rp_q];
   assign push = in_valid_i & in_ready_o;
   assign pop  = out_valid_o & out_ready_i;

   always_comb begin
      mem_d = mem_q;
      wp_d  = wp_q;
      rp_d  = rp_q;
      cnt_d = cnt_q;
      if (push) begin
         mem_d[wp_q] = in_data_i;
         wp_d = (wp_q == PW'(DEPTH - 1)) ? '0 : wp_q + PW'(1);
      end
      if (pop) begin
         rp_d = (rp_q == PW'(DEPTH - 1)) ? '0 : rp_q + PW'(1);
      end
      if (push && !pop) begin
         cnt_d = cnt_q + (PW+1)'(1);
      end else if (pop && !push) begin
         cnt_d = cnt_q - (PW+1)'(1);
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= '0;
         end
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end else begin
         mem_q <= mem_d;
         wp_q  <= wp_d;
         rp_q  <= rp_d;
         cnt_q <= cnt_d;
      end
   end
endmodule

module agss_master (
   input  wire logic                        ref_clk_i,   // port clock
   input  wire logic                        rst_i,       // async reset
   input  wire logic                        quad_i,      // 1: 4X, 0: 2X
   input  wire logic                        own_ad_i,    // master sources the data lines
   input  wire logic                        sba_en_i,    // master drives the side-band bus
   input  wire logic                        tx_valid_i,  // word to send
   output logic                             tx_ready_o,  // buffer has room
   input  wire logic [agss_pkg::WORD_W-1:0] tx_word_i,   // {cmd/be, data}
   input  wire logic                        sba_valid_i, // request byte to send
   output logic                             sba_ready_o, // buffer has room
   input  wire logic [agss_pkg::SBA_W-1:0]  sba_i,       // request byte
   output logic                             rx_valid_o,  // received word held
   input  wire logic                        rx_ready_i,  // taker ready
   output logic [agss_pkg::WORD_W-1:0]      rx_word_o,   // {cmd/be, data}
   agss_link_if.mst_mp                      link         // port wires
);
   logic                        tq_valid, tq_ready, sq_valid, sq_ready;
   logic [agss_pkg::WORD_W-1:0] tq_word, tx_data;
   logic [agss_pkg::SBA_W-1:0]  sq_byte;
   logic                        tx_stb, tx_stb_n, sb_stb, sb_stb_n;
   logic                        cap_lo, cap_hi, lo_q, lo_d, hi_q, hi_d, push;
   logic [agss_pkg::HALF_W-1:0] lo_data, hi_data;

   agss_fifo2 #(.W(agss_pkg::WORD_W)) u_txq (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i),
      .in_valid_i(tx_valid_i), .in_ready_o(tx_ready_o), .in_data_i(tx_word_i),
      .out_valid_o(tq_valid), .out_ready_i(tq_ready), .out_data_o(tq_word)
   );

   agss_strobe_tx #(.W(agss_pkg::WORD_W)) u_tx (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i), .own_i(own_ad_i), .quad_i(quad_i),
      .valid_i(tq_valid), .ready_o(tq_ready), .word_i(tq_word), .data_o(tx_data),
      .stb_o(tx_stb), .stb_n_o(tx_stb_n), .oe_o(link.mst_ad_oe),
      .stb_n_oe_o(link.mst_stb_n_oe)
   );

   assign link.mst_ad_o               = tx_data[agss_pkg::AD_W-1:0];
   assign link.mst_cmd_byte_enables_o = tx_data[agss_pkg::WORD_W-1:agss_pkg::AD_W];
   assign link.mst_stb_o              = {tx_stb, tx_stb};
   assign link.mst_stb_n_o            = {tx_stb_n, tx_stb_n};
   assign link.mst_stb_oe             = link.mst_ad_oe;

   agss_fifo2 #(.W(agss_pkg::SBA_W)) u_sbq (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i),
      .in_valid_i(sba_valid_i), .in_ready_o(sba_ready_o), .in_data_i(sba_i),
      .out_valid_o(sq_valid), .out_ready_i(sq_ready), .out_data_o(sq_byte)
   );

   // side-band runs beside the data lines with its own launcher
   agss_strobe_tx #(.W(agss_pkg::SBA_W)) u_sbtx (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i), .own_i(sba_en_i), .quad_i(quad_i),
      .valid_i(sq_valid), .ready_o(sq_ready), .word_i(sq_byte),
      .data_o(link.mst_sba_o), .stb_o(sb_stb), .stb_n_o(sb_stb_n),
      .oe_o(link.mst_sba_oe), .stb_n_oe_o(link.mst_sb_stb_n_oe)
   );

   assign link.mst_sb_stb_o   = sb_stb;
   assign link.mst_sb_stb_n_o = sb_stb_n;

   agss_strobe_rx #(.W(agss_pkg::HALF_W)) u_rx_lo (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i), .quad_i(quad_i), .ignore_i(own_ad_i),
      .stb_i(link.ad_stb[0]), .stb_n_i(link.ad_stb_n[0]),
      .data_i({link.port_cmd_byte_enables[1:0], link.ad[15:0]}),
      .cap_o(cap_lo), .data_o(lo_data)
   );

   agss_strobe_rx #(.W(agss_pkg::HALF_W)) u_rx_hi (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i), .quad_i(quad_i), .ignore_i(own_ad_i),
      .stb_i(link.ad_stb[1]), .stb_n_i(link.ad_stb_n[1]),
      .data_i({link.port_cmd_byte_enables[3:2], link.ad[31:16]}),
      .cap_o(cap_hi), .data_o(hi_data)
   );

   assign push = lo_q & hi_q;

   always_comb begin
      lo_d = cap_lo | (lo_q & ~push);
      hi_d = cap_hi | (hi_q & ~push);
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         lo_q <= 1'b0;
         hi_q <= 1'b0;
      end else begin
         lo_q <= lo_d;
         hi_q <= hi_d;
      end
   end

   // no overrun report: a master taker is expected to keep pace
   agss_fifo2 #(.W(agss_pkg::WORD_W)) u_rxq (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i),
      .in_valid_i(push), .in_ready_o(),
      .in_data_i({hi_data[agss_pkg::HALF_W-1:agss_pkg::HALF_AD_W],
                  lo_data[agss_pkg::HALF_W-1:agss_pkg::HALF_AD_W],
                  hi_data[agss_pkg::HALF_AD_W-1:0], lo_data[agss_pkg::HALF_AD_W-1:0]}),
      .out_valid_o(rx_valid_o), .out_ready_i(rx_ready_i), .out_data_o(rx_word_o)
   );
endmodule
`default_nettype wire

// ---- tb/agss_monitor.sv ----
// concurrent checks on the link wires between the hub and master ends
`timescale 1ns/1ns
`default_nettype none
module agss_monitor (
   input wire logic        ref_clk_i,      // port clock
   input wire logic        rst_i,          // async reset
   input wire logic        quad_i,         // 1: 4X
   input wire logic [31:0] hub_ad_o,       // hub data lines
   input wire logic        hub_ad_oe,      // hub drives data
   input wire logic [1:0]  hub_stb_o,      // hub true strobes
   input wire logic [1:0]  hub_stb_n_o,    // hub complements
   input wire logic        hub_stb_n_oe,   // complements driven
   input wire logic        mst_ad_oe,      // master drives data
   input wire logic [7:0]  mst_sba_o,      // side-band bus
   input wire logic        mst_sb_stb_o,   // side-band strobe
   input wire logic        mst_sb_stb_n_o, // its complement
   input wire logic        mst_sb_stb_n_oe // complement driven
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   sequence s_lo; $stable(hub_ad_o[15:0])[*2]; endsequence
   sequence s_hi; $stable(hub_ad_o[31:16])[*2]; endsequence
   AST_ONE_SRC: assert property (!(hub_ad_oe && mst_ad_oe))
      else $error("both ends drive the data lines");
   AST_HUB_PAIR: assert property (
      hub_stb_n_oe |-> quad_i && hub_stb_n_o == ~hub_stb_o)
      else $error("hub complement strobes wrong");
   AST_SB_PAIR: assert property (
      mst_sb_stb_n_oe |-> quad_i && mst_sb_stb_n_o == ~mst_sb_stb_o)
      else $error("side-band complement strobe wrong");
   AST_LO_WIN: assert property (hub_ad_oe && $changed(hub_stb_o[0]) |-> s_lo)
      else $error("low half moved at its strobe edge");
   AST_HI_WIN: assert property (hub_ad_oe && $changed(hub_stb_o[1]) |-> s_hi)
      else $error("upper half moved at its strobe edge");
   AST_GAP_4X: assert property (quad_i && hub_ad_oe && $changed(hub_stb_o[0])
      |=> ($stable(hub_stb_o[0]) || !hub_ad_oe)[*4])
      else $error("4X strobe edges too close");
   AST_GAP_2X: assert property (!quad_i && hub_ad_oe && $changed(hub_stb_o[0])
      |=> ($stable(hub_stb_o[0]) || !hub_ad_oe)[*8])
      else $error("2X strobe edges too close");
   AST_SB_WIN: assert property ($changed(mst_sb_stb_o) |-> $stable(mst_sba_o)[*2])
      else $error("side-band bus moved at its strobe edge");
endmodule
`default_nettype wire

// ---- tb/agss_tb.sv ----
// bench joining the hub and master ends across the link
`timescale 1ns/1ns
`default_nettype none
module agss_tb;
   logic        clk, rst, quad, h_own, txv, sbv, h_rxr, m_rxr, h_tr, h_rv, h_ov, h_sv;
   logic        h_so, m_tr, m_sr, m_rv;
   logic [35:0] txw, h_rw, m_rw, qw[$];
   logic [7:0]  sbw, h_sb, qs[$];
   logic [31:0] seed = 32'hECFB3FAA;
   int          n_mismatch = 0, tests_run = 0, cyc = 0;
   agss_link_if link ();
   agss_hub u_agss_hub (.ref_clk_i(clk), .rst_i(rst), .quad_i(quad), .own_ad_i(h_own),
      .tx_valid_i(txv & h_own), .tx_ready_o(h_tr), .tx_word_i(txw), .rx_valid_o(h_rv),
      .rx_ready_i(h_rxr), .rx_word_o(h_rw), .rx_overrun_o(h_ov), .sba_valid_o(h_sv),
      .sba_ready_i(h_rxr), .sba_o(h_sb), .sba_overrun_o(h_so), .link(link));
   agss_master u_agss_master (.ref_clk_i(clk), .rst_i(rst), .quad_i(quad), .own_ad_i(!h_own),
      .sba_en_i(1'b1), .tx_valid_i(txv & !h_own), .tx_ready_o(m_tr), .tx_word_i(txw),
      .sba_valid_i(sbv), .sba_ready_o(m_sr), .sba_i(sbw), .rx_valid_o(m_rv),
      .rx_ready_i(m_rxr), .rx_word_o(m_rw), .link(link));
   agss_monitor u_agss_monitor (.ref_clk_i(clk), .rst_i(rst), .quad_i(quad),
      .hub_ad_o(link.hub_ad_o), .hub_ad_oe(link.hub_ad_oe), .hub_stb_o(link.hub_stb_o),
      .hub_stb_n_o(link.hub_stb_n_o), .hub_stb_n_oe(link.hub_stb_n_oe),
      .mst_ad_oe(link.mst_ad_oe), .mst_sba_o(link.mst_sba_o), .mst_sb_stb_o(link.mst_sb_stb_o),
      .mst_sb_stb_n_o(link.mst_sb_stb_n_o), .mst_sb_stb_n_oe(link.mst_sb_stb_n_oe));
   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task chk(input bit ok);
      tests_run++;
      if (!ok) $display("Error %0t: mismatch", $time);
      n_mismatch += int'(!ok);
   endtask
   task results();
      $display("checks %0d, mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // first two words are fixed corners: all ones, then halves that differ
   task automatic send(input int n);
      for (int i = 0; i < n; i++) begin
         @(negedge clk);
         txw = i == 0 ? 36'hFFFFFFFFF : i == 1 ? 36'h5AAAA5555 : 36'({rnd(), rnd()});
         txv = 1'b1;
         while ((h_own ? h_tr : m_tr) !== 1'b1) @(negedge clk);
         qw.push_back(txw);
      end
      @(negedge clk);
      txv = 1'b0;
   endtask
   task automatic sbsend(input int n);
      for (int i = 0; i < n; i++) begin
         @(negedge clk);
         sbw = 8'(rnd());
         sbv = 1'b1;
         while (m_sr !== 1'b1) @(negedge clk);
         qs.push_back(sbw);
      end
      @(negedge clk);
      sbv = 1'b0;
   endtask
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // receivers stall at random; a word is checked at the negedge before it is taken
   always @(negedge clk) begin
      h_rxr = |(rnd() & 32'h3);
      m_rxr = |(rnd() & 32'h3);
      if (h_rv === 1'b1 && h_rxr) chk(qw.size() > 0 && h_rw === qw.pop_front());
      if (m_rv === 1'b1 && m_rxr) chk(qw.size() > 0 && m_rw === qw.pop_front());
      if (h_sv === 1'b1 && h_rxr) chk(qs.size() > 0 && h_sb === qs.pop_front());
      if (!rst) chk(h_ov === 1'b0 && h_so === 1'b0);
      cyc++;
      if (cyc == 4000) begin
         n_mismatch++;
         results();
      end
   end
   initial begin
      {rst, quad, h_own, txv, sbv} = 5'h10;
      txw = '0;
      sbw = '0;
      repeat (3) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      for (int m = 0; m < 4; m++) begin
         quad = m[0];
         h_own = m[1];
         fork
            send(7 + m);
            sbsend(5);
         join
         for (int k = 0; k < 200 && qw.size() + qs.size() > 0; k++) @(negedge clk);
         chk(qw.size() == 0 && qs.size() == 0);
         $display("test %0d done", m);
      end
      results();
   end
endmodule
`default_nettype wire
